// *** fscf_top.sv ***
// Full-closed scale feedback: scale decoding, direction, ratio scaling,
// pulse sums, hybrid deviation check and command ratio, behind an APB slave.
// Assumes encoder and command steps are one-cycle pulses on the control clock.
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module fscf_top
  import fscf_pkg::*;
#(
  parameter int ENC_PPR = 1048576 // Encoder counts per motor revolution
) (
  input  wire logic        ref_clk_i,  // 20 MHz control clock
  input  wire logic        nrst_i,     // Asynchronous reset, active low
  input  wire logic        psel_i,     // APB select
  input  wire logic        penable_i,  // APB enable
  input  wire logic        pwrite_i,   // APB direction
  input  wire logic [7:0]  paddr_i,    // APB byte address
  input  wire logic [31:0] pwdata_i,   // APB write data
  output logic      [31:0] prdata_o,   // APB read data
  output logic             pready_o,   // APB ready
  output logic             pslverr_o,  // APB error for unmapped address
  input  wire logic        pwr_up_i,   // Power-up pulse: stored settings go live
  input  wire logic        sc_a_i,     // Scale A phase
  input  wire logic        sc_b_i,     // Scale B phase
  input  wire logic        ser_vld_i,  // Serial scale word valid
  input  wire logic [31:0] ser_pos_i,  // Serial scale word
  input  fscf_pkg::fscf_step_s enc_i,  // Motor encoder step
  input  fscf_pkg::fscf_step_s cmd_i,  // Host command pulse step
  output fscf_pkg::fscf_step_s cmd_o,  // Command step after command ratio
  output logic             fault_o,    // Hybrid deviation fault, level
  output logic             irq_o       // Interrupt, level
);
  import fscf_pkg::*;

  localparam logic [20:0] PPR = 21'(ENC_PPR);

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  fscf_cfg_s          sw_reg,   sw_next;   // Stored settings (software side)
  fscf_cfg_s          act_reg,  act_next;  // Live settings
  logic               load_reg, load_next; // Load pending after reset
  logic [1:0]         stat_reg, stat_next; // Sticky events
  logic [1:0]         mask_reg, mask_next; // Interrupt mask
  logic [31:0]        rd_reg,   rd_next;   // Read data
  logic               err_reg,  err_next;  // Unmapped access
  logic signed [31:0] pend_reg, pend_next; // Serial counts not yet stepped
  logic [31:0]        last_reg, last_next; // Last serial word, absolute or increment
  logic signed [22:0] sacc_reg, sacc_next; // Scale ratio residue
  logic signed [22:0] cacc_reg, cacc_next; // Command ratio residue
  logic [31:0]        esum_reg, esum_next; // Encoder pulse sum
  logic [31:0]        ssum_reg, ssum_next; // Scale pulse sum
  logic signed [31:0] dev_reg,  dev_next;  // Hybrid deviation
  logic [20:0]        rcnt_reg, rcnt_next; // Counts within one revolution
  logic [6:0]         revs_reg, revs_next; // Revolutions since last clear
  fscf_step_s         cmd_reg,  cmd_next;  // Scaled command step

  fscf_step_s  q_st;    // Quadrature step
  fscf_step_s  raw_st;  // Scale step before inversion
  fscf_step_s  sc_st;   // Scale step after inversion
  fscf_ratio_s s_rat;   // Scaled scale step
  fscf_ratio_s c_rat;   // Scaled command step
  logic        wr_en;   // Write takes effect this edge
  logic        setup;   // APB setup cycle
  logic        clr_evt; // Periodic clear this cycle
  logic        over;    // Deviation beyond limit
  logic [31:0] abs_dev; // Deviation magnitude

  fscf_quad_dec u_quad (
    .ref_clk_i (ref_clk_i),
    .nrst_i    (nrst_i),
    .a_i       (sc_a_i),
    .b_i       (sc_b_i),
    .step_o    (q_st)
  );

  // ----------------------------------------------------------------
  // APB slave and settings
  // ----------------------------------------------------------------
  // Zero wait states; read data latched in setup so it comes from a flop
  always_comb begin
    setup     = psel_i & ~penable_i;
    wr_en     = psel_i & penable_i & pwrite_i;
    sw_next   = sw_reg;
    mask_next = mask_reg;
    rd_next   = rd_reg;
    err_next  = err_reg;
    // Stored settings go live only on power-up or in the first cycle after reset, never on a write
    load_next = 1'b0;
    act_next  = (load_reg || pwr_up_i) ? sw_reg : act_reg;
    if (wr_en) begin
      case (paddr_i)
        OFS_CFG: begin
          sw_next.stype = pwdata_i[1:0];
          sw_next.inv   = pwdata_i[CFG_INV_BIT];
        end
        OFS_NUM:    sw_next.num    = clamp21(pwdata_i, 1'b0);
        OFS_DEN:    sw_next.den    = clamp21(pwdata_i, 1'b1);
        OFS_CFIRST: sw_next.cfirst = clamp21(pwdata_i, 1'b0);
        OFS_CSEC:   sw_next.csec   = clamp21(pwdata_i, 1'b1);
        OFS_LIMIT: begin
          // Limit kept within 1..2^27
          if (pwdata_i == 32'h0) sw_next.limit = 28'h1;
          else if (pwdata_i > {4'h0, LIMIT_MAX}) sw_next.limit = LIMIT_MAX;
          else sw_next.limit = pwdata_i[27:0];
        end
        OFS_REVS: sw_next.revs = (pwdata_i > {25'h0, REVS_MAX}) ? REVS_MAX : pwdata_i[6:0];
        OFS_MASK: mask_next = pwdata_i[1:0];
        default: ;
      endcase
    end
    if (setup) begin
      err_next = 1'b0;
      case (paddr_i)
        OFS_CFG:    rd_next = {29'h0, sw_reg.inv, sw_reg.stype};
        OFS_NUM:    rd_next = {11'h0, sw_reg.num};
        OFS_DEN:    rd_next = {11'h0, sw_reg.den};
        OFS_LIMIT:  rd_next = {4'h0, sw_reg.limit};
        OFS_REVS:   rd_next = {25'h0, sw_reg.revs};
        OFS_CFIRST: rd_next = {11'h0, sw_reg.cfirst};
        OFS_CSEC:   rd_next = {11'h0, sw_reg.csec};
        OFS_STAT:   rd_next = {30'h0, stat_reg};
        OFS_MASK:   rd_next = {30'h0, mask_reg};
        OFS_ENCSUM: rd_next = esum_reg;
        OFS_SCSUM:  rd_next = ssum_reg;
        OFS_DEV:    rd_next = dev_reg;
        OFS_ERR:    rd_next = {16'h0, ERR_CODE};
        default: begin
          rd_next  = 32'h0;
          err_next = 1'b1;
        end
      endcase
    end
  end

  // Saturate to 2^20, optionally raise zero to one
  function automatic logic [20:0] clamp21(logic [31:0] v, logic min1);
    if (v > {11'h0, RATIO_MAX}) return RATIO_MAX;
    if (min1 && v == 32'h0) return 21'h1;
    return v[20:0];
  endfunction : clamp21

  // Register the slave state
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      sw_reg   <= CFG_RST;
      act_reg  <= CFG_RST;
      load_reg <= 1'b1;
      mask_reg <= 2'h0;
      rd_reg   <= 32'h0;
      err_reg  <= 1'b0;
    end else begin
      sw_reg   <= sw_next;
      act_reg  <= act_next;
      load_reg <= load_next;
      mask_reg <= mask_next;
      rd_reg   <= rd_next;
      err_reg  <= err_next;
    end
  end

  assign pready_o  = 1'b1;
  assign prdata_o  = rd_reg;
  assign pslverr_o = err_reg & psel_i & penable_i;

  // ----------------------------------------------------------------
  // Position path
  // ----------------------------------------------------------------
  // Serial words feed a pending count drained one step per cycle, so the
  // ratio stage sees the same step stream as the quadrature path
  always_comb begin
    pend_next = pend_reg;
    last_next = last_reg;
    raw_st    = '0;
    case (act_reg.stype)
      ST_AB: raw_st = q_st;
      ST_SER_INC, ST_SER_ABS: begin
        if (pend_reg > 0) begin
          raw_st.up = 1'b1;
          pend_next = pend_reg - 32'sd1;
        end else if (pend_reg < 0) begin
          raw_st.dn = 1'b1;
          pend_next = pend_reg + 32'sd1;
        end
        if (ser_vld_i) begin
          last_next = ser_pos_i;
          if (act_reg.stype == ST_SER_INC) pend_next = pend_next + signed'(ser_pos_i);
          else pend_next = pend_next + signed'(ser_pos_i - last_reg);
        end
      end
      default: ;
    endcase
    // Inverted scale swaps its count direction
    sc_st = act_reg.inv ? fscf_step_s'{up: raw_st.dn, dn: raw_st.up} : raw_st;
    s_rat = ratio_step(sacc_reg, sc_st, act_reg.num, act_reg.den);
    c_rat = ratio_step(cacc_reg, cmd_i, act_reg.cfirst, act_reg.csec);
    sacc_next = s_rat.acc;
    cacc_next = c_rat.acc;
    cmd_next  = c_rat.st;
    // Both sums wrap freely like a front-panel monitor
    esum_next = esum_reg + 32'(enc_i.up & ~enc_i.dn) - 32'(enc_i.dn & ~enc_i.up);
    ssum_next = ssum_reg + 32'(sc_st.up) - 32'(sc_st.dn);
    // Revolution counting on encoder steps of either direction
    rcnt_next = rcnt_reg;
    revs_next = revs_reg;
    clr_evt   = 1'b0;
    if (enc_i.up ^ enc_i.dn) begin
      if (rcnt_reg == PPR - 21'h1) begin
        rcnt_next = 21'h0;
        revs_next = revs_reg + 7'h1;
      end else begin
        rcnt_next = rcnt_reg + 21'h1;
      end
    end
    if (act_reg.revs == 7'h0) begin
      revs_next = 7'h0;
    end else if (revs_reg >= act_reg.revs) begin
      clr_evt   = 1'b1;
      revs_next = 7'h0;
    end
    // Encoder minus scaled scale
    dev_next = dev_reg + 32'(enc_i.up & ~enc_i.dn) - 32'(enc_i.dn & ~enc_i.up)
             - 32'(s_rat.st.up) + 32'(s_rat.st.dn);
    if (clr_evt) dev_next = 32'sh0;
    abs_dev = dev_reg[31] ? 32'(-dev_reg) : 32'(dev_reg);
    over    = abs_dev > {4'h0, act_reg.limit};
    // Set wins over a software clear in the same cycle
    stat_next = stat_reg;
    if (wr_en && paddr_i == OFS_STAT) stat_next = stat_reg & ~pwdata_i[1:0];
    if (over) stat_next[ST_FAULT_BIT] = 1'b1;
    if (clr_evt) stat_next[ST_CLR_BIT] = 1'b1;
  end

  // Register the position path
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pend_reg <= 32'sh0;
      last_reg <= 32'h0;
      sacc_reg <= 23'sh0;
      cacc_reg <= 23'sh0;
      esum_reg <= 32'h0;
      ssum_reg <= 32'h0;
      dev_reg  <= 32'sh0;
      rcnt_reg <= 21'h0;
      revs_reg <= 7'h0;
      stat_reg <= 2'h0;
      cmd_reg  <= '0;
    end else begin
      pend_reg <= pend_next;
      last_reg <= last_next;
      sacc_reg <= sacc_next;
      cacc_reg <= cacc_next;
      esum_reg <= esum_next;
      ssum_reg <= ssum_next;
      dev_reg  <= dev_next;
      rcnt_reg <= rcnt_next;
      revs_reg <= revs_next;
      stat_reg <= stat_next;
      cmd_reg  <= cmd_next;
    end
  end

  assign cmd_o   = cmd_reg;
  assign fault_o = stat_reg[ST_FAULT_BIT];
  assign irq_o   = |(stat_reg & mask_reg);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!nrst_i);

  den_min_a: assert property (act_reg.den != 21'h0 && act_reg.csec != 21'h0)
    else $error("ratio denominator reached zero");
  limit_min_a: assert property (act_reg.limit != 28'h0)
    else $error("deviation limit reached zero");
  invert_a: assert property (act_reg.stype == ST_AB && act_reg.inv && q_st.up && !q_st.dn
                             |=> ssum_reg == $past(ssum_reg) - 32'h1)
    else $error("inverted scale step not counted down");
  // The clear event may hold the interrupt up too, so both unmasked bits count
  fault_a: assert property (over |=> fault_o &&
                            (irq_o == (mask_reg[ST_FAULT_BIT] || (stat_reg[ST_CLR_BIT] && mask_reg[ST_CLR_BIT]))))
    else $error("deviation excess did not raise fault");
  clear_a: assert property (clr_evt |=> dev_reg == 32'sh0 && stat_reg[ST_CLR_BIT])
    else $error("periodic clear did not zero deviation");
  no_clear_a: assert property (act_reg.revs == 7'h0 |-> !clr_evt)
    else $error("clear fired while disabled");
  enc_sum_a: assert property (enc_i.up && !enc_i.dn |=> esum_reg == $past(esum_reg) + 32'h1)
    else $error("encoder sum missed a step");
  cfg_hold_a: assert property (!load_reg && !pwr_up_i |=> $stable(act_reg))
    else $error("live settings changed without power-up");
  // A power-up may bring a new numerator, so only quiet settings are watched
  zero_num_a: assert property (act_reg.num == 21'h0 && sacc_reg == 23'sh0 && !load_reg && !pwr_up_i
                               |=> sacc_reg == 23'sh0)
    else $error("zero numerator moved the residue");

endmodule : fscf_top

// *** fscf_pkg.sv ***
// Package for the full-closed scale feedback block: register map, reset values,
// settings carrier and the ratio step function shared by scale and command paths.
// Assumes one 20 MHz control clock and an APB register port with 32-bit data.
package fscf_pkg;

  // ----------------------------------------------------------------
  // Register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CFG    = 8'h00; // Scale type and direction invert
  localparam logic [7:0] OFS_NUM    = 8'h04; // Scale ratio numerator
  localparam logic [7:0] OFS_DEN    = 8'h08; // Scale ratio denominator
  localparam logic [7:0] OFS_LIMIT  = 8'h0c; // Hybrid deviation limit
  localparam logic [7:0] OFS_REVS   = 8'h10; // Deviation clear revolutions
  localparam logic [7:0] OFS_CFIRST = 8'h14; // Command ratio first (numerator)
  localparam logic [7:0] OFS_CSEC   = 8'h18; // Command ratio second (denominator)
  localparam logic [7:0] OFS_STAT   = 8'h1c; // Sticky events, write one to clear
  localparam logic [7:0] OFS_MASK   = 8'h20; // Interrupt mask
  localparam logic [7:0] OFS_ENCSUM = 8'h24; // Encoder feedback pulse sum
  localparam logic [7:0] OFS_SCSUM  = 8'h28; // Scale feedback pulse sum
  localparam logic [7:0] OFS_DEV    = 8'h2c; // Hybrid deviation
  localparam logic [7:0] OFS_ERR    = 8'h30; // Fault code

  // ----------------------------------------------------------------
  // Field positions and limits
  // ----------------------------------------------------------------
  localparam int          CFG_INV_BIT  = 2;          // Direction invert bit
  localparam int          ST_FAULT_BIT = 0;          // Deviation excess event
  localparam int          ST_CLR_BIT   = 1;          // Periodic clear event
  localparam logic [20:0] RATIO_MAX    = 21'h100000; // Two to the 20
  localparam logic [27:0] LIMIT_MAX    = 28'h8000000; // Two to the 27
  localparam logic [6:0]  REVS_MAX     = 7'h64;      // 100 revolutions
  localparam logic [15:0] ERR_CODE     = 16'h1900;   // Main code 25, sub code 0

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [20:0] RST_RATIO = 21'h000001;
  localparam logic [27:0] RST_LIMIT = 28'h0004000;
  localparam logic [6:0]  RST_REVS  = 7'h00;

  // Scale interface kinds
  typedef enum logic [1:0] {
    ST_AB      = 2'b00, // Quadrature A/B pulses
    ST_SER_INC = 2'b01, // Serial, word is a signed increment
    ST_SER_ABS = 2'b10  // Serial, word is an absolute position
  } fscf_stype_e;

  // Settings as one carrier
  typedef struct packed {
    logic [1:0]  stype;
    logic        inv;
    logic [20:0] num;
    logic [20:0] den;
    logic [27:0] limit;
    logic [6:0]  revs;
    logic [20:0] cfirst;
    logic [20:0] csec;
  } fscf_cfg_s;

  // One count step
  typedef struct packed {
    logic up;
    logic dn;
  } fscf_step_s;

  // Ratio accumulator and its output step
  typedef struct packed {
    logic signed [22:0] acc;
    fscf_step_s         st;
  } fscf_ratio_s;

  localparam fscf_cfg_s CFG_RST = '{stype: ST_AB, inv: 1'b0, num: RST_RATIO, den: RST_RATIO,
                                    limit: RST_LIMIT, revs: RST_REVS,
                                    cfirst: RST_RATIO, csec: RST_RATIO};

  // Adds num per input step and emits one output step per den of residue;
  // the residue stays in acc so no count is lost over long travel
  function automatic fscf_ratio_s ratio_step(logic signed [22:0] acc, fscf_step_s in,
                                             logic [20:0] num, logic [20:0] den);
    fscf_ratio_s        r;
    logic signed [22:0] n;
    logic signed [22:0] d;
    n = signed'({2'b00, num});
    d = signed'({2'b00, den});
    r.acc = acc;
    r.st  = '0;
    if (in.up && !in.dn) r.acc = r.acc + n;
    if (in.dn && !in.up) r.acc = r.acc - n;
    if (r.acc >= d) begin
      r.acc   = r.acc - d;
      r.st.up = 1'b1;
    end else if (r.acc <= -d) begin
      r.acc   = r.acc + d;
      r.st.dn = 1'b1;
    end
    return r;
  endfunction : ratio_step

endpackage : fscf_pkg

// *** fscf_quad_dec.sv ***
// Quadrature A/B decoder for the external scale.
// Assumes A and B are already synchronous to the clock; an illegal double
// transition is dropped rather than guessed.
`timescale 1ns/1ps
module fscf_quad_dec
  import fscf_pkg::*;
(
  input  wire logic             ref_clk_i, // Control clock
  input  wire logic             nrst_i,    // Asynchronous reset, active low
  input  wire logic             a_i,       // Scale A phase
  input  wire logic             b_i,       // Scale B phase
  output fscf_pkg::fscf_step_s  step_o     // One-cycle count step
);
  import fscf_pkg::*;

  // ----------------------------------------------------------------
  // Previous phase state
  // ----------------------------------------------------------------
  logic       pa_reg;  // A from last cycle
  logic       pb_reg;  // B from last cycle
  logic       one_chg; // Exactly one phase moved
  fscf_step_s st;      // Decoded step

  // Direction: A leading B counts up
  always_comb begin
    one_chg = (a_i ^ pa_reg) ^ (b_i ^ pb_reg);
    st.up   = one_chg & ~(pa_reg ^ b_i);
    st.dn   = one_chg &  (pa_reg ^ b_i);
  end

  // Register the phases
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      pa_reg <= 1'b0;
      pb_reg <= 1'b0;
    end else begin
      pa_reg <= a_i;
      pb_reg <= b_i;
    end
  end

  assign step_o = st;

endmodule : fscf_quad_dec

// *** fscf_scale_model.sv ***
// Quadrature scale model: turns step requests from the bench into A/B levels.
// Assumes at most one request per two clock cycles, so no double transition.
`timescale 1ns/1ps
module fscf_scale_model (
  input  wire logic ref_clk_i, // Control clock
  input  wire logic nrst_i,    // Reset, active low
  input  wire logic up_i,      // Move one count forward
  input  wire logic dn_i,      // Move one count back
  output logic      a_o,       // A phase level
  output logic      b_o        // B phase level
);
  logic [1:0] ph_reg;  // Quarter-period phase
  logic [1:0] ph_next; // Next phase

  // ----------------------------------------------------------------
  // Phase stepping
  // ----------------------------------------------------------------
  // Forward walks 00,10,11,01, so the first forward move raises A alone
  always_comb begin
    ph_next = ph_reg + {1'b0, up_i} - {1'b0, dn_i};
  end

  // Phase register, changes just after the edge like a real line
  always_ff @(posedge ref_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ph_reg <= 2'h0;
    end else begin
      ph_reg <= ph_next;
    end
  end

  assign a_o = ph_reg[1] ^ ph_reg[0];
  assign b_o = ph_reg[1];
endmodule : fscf_scale_model

// *** testbench.sv ***
// Self-checking bench for the scale feedback block, driven over APB.
// Assumes a small revolution count parameter so clearing is reached quickly.
`timescale 1ns/1ps
module testbench;
  import fscf_pkg::*;
  `define CHK(nm, ex, gt) begin cmp_count++; if ((gt) !== (ex)) begin n_fail++; \
    $display("unexpected %s expected %h seen %h", nm, ex, gt); end end
  localparam int PPR = 8; // Short revolution for simulation
  logic        ref_clk_i = 1'b0;
  logic        nrst_i    = 1'b0;
  logic        psel_i    = 1'b0;
  logic        penable_i = 1'b0;
  logic        pwrite_i  = 1'b0;
  logic [7:0]  paddr_i   = 8'h00;
  logic [31:0] pwdata_i  = 32'h0;
  logic [31:0] prdata_o;
  logic        pready_o;
  logic        pslverr_o;
  logic        pwr_up_i  = 1'b0;
  logic        sc_a_i;
  logic        sc_b_i;
  logic        sc_up     = 1'b0; // Request to the scale model
  logic        sc_dn     = 1'b0;
  logic        ser_vld_i = 1'b0;
  logic [31:0] ser_pos_i = 32'h0;
  fscf_step_s  enc_i     = '0;
  fscf_step_s  cmd_i     = '0;
  fscf_step_s  cmd_o;
  logic        fault_o;
  logic        irq_o;
  int          n_fail    = 0;
  int          cmp_count = 0;
  int          cyc       = 0;
  logic [31:0] rd;          // Last read data
  logic        er;          // Last error flag
  logic [31:0] b0;          // Baseline values
  logic [31:0] b1;

  always #25 ref_clk_i = ~ref_clk_i; // 20 MHz

  fscf_top #(.ENC_PPR(PPR)) u_dut (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .psel_i(psel_i),
    .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
    .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o), .pwr_up_i(pwr_up_i),
    .sc_a_i(sc_a_i), .sc_b_i(sc_b_i), .ser_vld_i(ser_vld_i), .ser_pos_i(ser_pos_i),
    .enc_i(enc_i), .cmd_i(cmd_i), .cmd_o(cmd_o), .fault_o(fault_o), .irq_o(irq_o));
  fscf_scale_model u_scale (.ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .up_i(sc_up), .dn_i(sc_dn),
    .a_o(sc_a_i), .b_o(sc_b_i));

  // ----------------------------------------------------------------
  // Bus and stimulus tasks
  // ----------------------------------------------------------------
  // One APB transfer; request held until pready is seen high
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk_i);
    psel_i    <= 1'b1;
    penable_i <= 1'b0;
    pwrite_i  <= w;
    paddr_i   <= a;
    pwdata_i  <= d;
    @(posedge ref_clk_i);
    penable_i <= 1'b1;
    do @(posedge ref_clk_i); while (pready_o !== 1'b1);
    rd = prdata_o;
    er = pslverr_o;
    psel_i    <= 1'b0;
    penable_i <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr
  task automatic chk(input string nm, input logic [7:0] a, input logic [31:0] ex);
    apb(1'b0, a, 32'h0);
    `CHK(nm, ex, rd)
  endtask : chk
  // Power cycle stand-in: stored settings go live
  task automatic pwr();
    @(posedge ref_clk_i) pwr_up_i <= 1'b1;
    @(posedge ref_clk_i) pwr_up_i <= 1'b0;
  endtask : pwr
  // Encoder or scale steps, one every two cycles
  task automatic steps(input int n, input logic sc, input logic dn);
    repeat (n) begin
      @(posedge ref_clk_i);
      if (sc) {sc_up, sc_dn} <= {~dn, dn};
      else enc_i <= {~dn, dn};
      @(posedge ref_clk_i);
      {sc_up, sc_dn} <= 2'b00;
      enc_i <= '0;
    end
    repeat (3) @(posedge ref_clk_i);
  endtask : steps
  // One serial scale word, then time for its counts to drain
  task automatic ser(input logic [31:0] w);
    @(posedge ref_clk_i);
    ser_vld_i <= 1'b1;
    ser_pos_i <= w;
    @(posedge ref_clk_i) ser_vld_i <= 1'b0;
    repeat (10) @(posedge ref_clk_i);
  endtask : ser
  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
    if (n_fail == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : stop_test

  // Hang guard
  always @(posedge ref_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      stop_test();
    end
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk_i);
    nrst_i <= 1'b1;
    chk("num", OFS_NUM, 32'h1);
    chk("limit", OFS_LIMIT, 32'h4000);
    chk("errcode", OFS_ERR, 32'h1900);
    apb(1'b0, 8'h40, 32'h0);
    `CHK("unmapped", 1'b1, er)
    wr(OFS_DEN, 32'h0);
    chk("den_min", OFS_DEN, 32'h1);
    wr(OFS_NUM, 32'h3fffff);
    chk("num_max", OFS_NUM, 32'h100000);
    wr(OFS_LIMIT, 32'h0);
    chk("limit_min", OFS_LIMIT, 32'h1);
    wr(OFS_REVS, 32'hff);
    chk("revs_max", OFS_REVS, 32'h64);
    $display("test limits done");
    // Command path with unit ratio, reply one cycle later
    @(posedge ref_clk_i) cmd_i <= '{up: 1'b1, dn: 1'b0};
    @(posedge ref_clk_i) cmd_i <= '0;
    #1 `CHK("cmd_up", 2'b10, cmd_o)
    @(posedge ref_clk_i) #1 `CHK("cmd_idle", 2'b00, cmd_o)
    $display("test command done");
    // Revolution clearing: unit ratio, one revolution, wide limit so no fault
    wr(OFS_NUM, 32'h1);
    wr(OFS_LIMIT, 32'h4000);
    wr(OFS_REVS, 32'h1);
    wr(OFS_MASK, 32'h1);
    pwr();
    steps(PPR - 1, 1'b0, 1'b0);
    chk("dev_pre", OFS_DEV, PPR - 1);
    steps(1, 1'b0, 1'b0);
    chk("dev_clr", OFS_DEV, 32'h0);
    chk("stat_clr", OFS_STAT, 32'h2);
    `CHK("irq_masked", 1'b0, irq_o)
    $display("test revolutions done");
    // Fault at limit boundary, clearing disabled
    wr(OFS_REVS, 32'h0);
    wr(OFS_LIMIT, 32'h3);
    pwr();
    steps(3, 1'b0, 1'b0);
    `CHK("fault_eq", 1'b0, fault_o)
    steps(PPR, 1'b0, 1'b0);
    `CHK("fault_gt", 1'b1, fault_o)
    `CHK("irq_on", 1'b1, irq_o)
    chk("dev_noclr", OFS_DEV, PPR + 3);
    wr(OFS_STAT, 32'h3);
    chk("stat_w1c", OFS_STAT, 32'h1);
    wr(OFS_MASK, 32'h0);
    pwr();
    `CHK("irq_off", 1'b0, irq_o)
    $display("test fault done");
    // Half ratio with residue carried
    wr(OFS_DEN, 32'h2);
    pwr();
    apb(1'b0, OFS_DEV, 32'h0);
    b0 = rd;
    apb(1'b0, OFS_SCSUM, 32'h0);
    b1 = rd;
    steps(3, 1'b1, 1'b0);
    chk("dev_res", OFS_DEV, b0 - 32'h1);
    steps(1, 1'b1, 1'b0);
    chk("dev_half", OFS_DEV, b0 - 32'h2);
    chk("scsum", OFS_SCSUM, b1 + 32'h4);
    apb(1'b0, OFS_ENCSUM, 32'h0);
    b0 = rd;
    steps(2, 1'b0, 1'b1);
    chk("encsum", OFS_ENCSUM, b0 - 32'h2);
    $display("test ratio done");
    // Invert stored only, then live
    wr(OFS_CFG, 32'h4);
    steps(2, 1'b1, 1'b0);
    chk("inv_stored", OFS_SCSUM, b1 + 32'h6);
    pwr();
    steps(2, 1'b1, 1'b0);
    chk("inv_live", OFS_SCSUM, b1 + 32'h4);
    $display("test invert done");
    // Zero numerator: scale steps still summed (inverted), deviation untouched
    wr(OFS_NUM, 32'h0);
    pwr();
    apb(1'b0, OFS_DEV, 32'h0);
    b0 = rd;
    steps(2, 1'b1, 1'b0);
    chk("dev_num0", OFS_DEV, b0);
    chk("scsum_num0", OFS_SCSUM, b1 + 32'h2);
    $display("test zero numerator done");
    // Serial increment scale: three counts on top of the sum so far
    wr(OFS_CFG, 32'h1);
    pwr();
    ser(32'h3);
    chk("serial", OFS_SCSUM, b1 + 32'h5);
    // Serial absolute scale: only the change between words counts
    wr(OFS_CFG, 32'h2);
    pwr();
    ser(32'h8);
    apb(1'b0, OFS_SCSUM, 32'h0);
    b1 = rd;
    ser(32'h6);
    chk("serial_abs", OFS_SCSUM, b1 - 32'h2);
    $display("test serial done");
    stop_test();
  end
endmodule : testbench
